// *** include/acq_regs_defines.vh ***
// Constants for the acquisition status and interrupt enable register bank.
// Included by the register bank and its testbench; definitions only.
`ifndef ACQ_REGS_DEFINES_VH
`define ACQ_REGS_DEFINES_VH

// ----------------------------------------------------------------
// Bus geometry
// ----------------------------------------------------------------
`define AXI_ADDR_W            8
`define AXI_DATA_W            32
`define AXI_RESP_OKAY         2'h0
`define AXI_RESP_SLVERR       2'h2

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define OFF_STATUS_INPUTS     8'h00
`define OFF_IRQ_ENABLE_OUTS   8'h04
`define OFF_MODIFY_SELECT     8'h08
`define OFF_EVENT_STATUS      8'h0C
`define OFF_EVENT_MASK        8'h10

// ----------------------------------------------------------------
// Decoded register indices
// ----------------------------------------------------------------
`define IDX_STATUS_INPUTS     3'h0
`define IDX_IRQ_ENABLE_OUTS   3'h1
`define IDX_MODIFY_SELECT     3'h2
`define IDX_EVENT_STATUS      3'h3
`define IDX_EVENT_MASK        3'h4
`define IDX_NONE              3'h7

// ----------------------------------------------------------------
// Status/inputs word fields
// ----------------------------------------------------------------
`define FLD_NEXT_CMD_LSB      0
`define FLD_CUR_CMD_LSB       2
`define FLD_IN_WINDOW         4
`define FLD_TALLY_LSB         5
`define FLD_AUX_PRESENT       24
`define FLD_GPIN_LSB          25
`define FLD_DIP_LSB           30

// ----------------------------------------------------------------
// Enable/outputs word fields
// ----------------------------------------------------------------
`define FLD_SRC_ENABLE_LSB    0
`define FLD_EOF_GATING        6
`define FLD_INT_ANY           7
`define FLD_GLOBAL_IRQ_EN     8
`define FLD_GPOUT_LSB         10
`define CTRL_WRITE_MASK       32'h0001FD7F

// ----------------------------------------------------------------
// Capture commands
// ----------------------------------------------------------------
`define CMD_FREEZE            2'h0
`define CMD_ABORT             2'h1
`define CMD_SNAP              2'h2
`define CMD_GRAB              2'h3

// ----------------------------------------------------------------
// Event bit positions and modify selector codes
// ----------------------------------------------------------------
`define EVT_COUNT             7
`define EVT_UART              4
`define SEL_NONE              3'h0
`define SEL_CTAB              3'h1
`define SEL_OVERRUN           3'h2
`define SEL_HARDWARE          3'h3
`define SEL_PULSE             3'h4
`define SEL_DMA               3'h5
`define SEL_EOF               3'h6

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RST_CTRL              32'h00000000
`define RST_NEXT_CMD          2'h0
`define RST_MODIFY_SELECT     3'h0
`define RST_EVENT_MASK        7'h00

`endif

// *** hdl/input_sync.v ***
// Two-stage synchroniser for a group of slow external input levels.
// Assumes the levels are quasi-static; no bus-coherence across bits.
`timescale 1ns/1ps

module input_sync #(
  parameter WIDTH = 8
) (
  // Clock and reset
  input  wire             clk,
  input  wire             rst_n,
  // Levels
  input  wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] meta_ff;
  reg [WIDTH-1:0] stable_ff;

  // ----------------------------------------------------------------
  // Two flip-flops, first stage read only by the second
  // ----------------------------------------------------------------
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_ff   <= {WIDTH{1'b0}};
      stable_ff <= {WIDTH{1'b0}};
    end else begin
      meta_ff   <= async_in;
      stable_ff <= meta_ff;
    end
  end

  assign sync_out = stable_ff;

endmodule // input_sync

// *** hdl/acq_status_irq_enable_regs.v ***
// Acquisition status and interrupt enable register bank, AXI4-Lite slave.
// Assumes frame timing and event pulses come from logic on sys_clk,
// connector pins and the board-present strap are asynchronous.
//
// Contract
// - A read-only two-bit field reports the capture command now executing.
// - Software writes a next command, which takes effect at the next frame start.
// - A read-only bit is high while the camera is within the vertical window.
// - A small read-only tally advances at each start of the vertical window.
// - A read-only bit is high while the auxiliary board is attached.
// - Five general input bits and two selector bits read back their pin levels.
// - Bits 0 to 5 enable the six source interrupts; a zero suppresses one.
// - With gating clear, every frame end raises the end-of-frame interrupt.
// - With gating set, frame end raises it only during snap or grab.
// - A read-only flag is high whenever the board emits an interrupt.
// - A global enable gates every interrupt; clear means none reaches the host.
// - Seven read-write output bits drive their written value onto the pins.
// - While the modify selector names an event flag, its source cannot set it.
`timescale 1ns/1ps
`include "acq_regs_defines.vh"

module acq_status_irq_enable_regs (
  // Clock and reset
  input  wire                     sys_clk,
  input  wire                     rst_n,
  // AXI4-Lite write address
  input  wire [`AXI_ADDR_W-1:0]   s_axi_awaddr,
  input  wire [2:0]               s_axi_awprot,
  input  wire                     s_axi_awvalid,
  output wire                     s_axi_awready,
  // AXI4-Lite write data
  input  wire [`AXI_DATA_W-1:0]   s_axi_wdata,
  input  wire [3:0]               s_axi_wstrb,
  input  wire                     s_axi_wvalid,
  output wire                     s_axi_wready,
  // AXI4-Lite write response
  output wire [1:0]               s_axi_bresp,
  output wire                     s_axi_bvalid,
  input  wire                     s_axi_bready,
  // AXI4-Lite read address
  input  wire [`AXI_ADDR_W-1:0]   s_axi_araddr,
  input  wire [2:0]               s_axi_arprot,
  input  wire                     s_axi_arvalid,
  output wire                     s_axi_arready,
  // AXI4-Lite read data
  output wire [`AXI_DATA_W-1:0]   s_axi_rdata,
  output wire [1:0]               s_axi_rresp,
  output wire                     s_axi_rvalid,
  input  wire                     s_axi_rready,
  // Frame timing
  input  wire                     frame_window,
  input  wire                     frame_end_pulse,
  // Event sources
  input  wire                     ctab_event,
  input  wire                     overrun_event,
  input  wire                     hardware_event,
  input  wire                     external_pulse_event,
  input  wire                     uart_event,
  input  wire                     dma_descriptor_event,
  // Connector pins
  input  wire                     aux_board_present,
  input  wire [4:0]               general_input_pins,
  input  wire [1:0]               dip_selector_inputs,
  output wire [6:0]               general_output_pins,
  // Acquisition engine and host
  output wire [1:0]               current_capture_command,
  output wire                     irq
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  reg                     rst_meta_ff;
  reg                     rst_sync_n_ff;
  wire                    rst_sync_n;

  wire [7:0]              pins_sync;
  wire                    aux_sync;
  wire [4:0]              gpin_sync;
  wire [1:0]              dip_sync;

  reg                     window_ff;
  reg  [1:0]              next_cmd_ff;
  reg  [1:0]              cur_cmd_ff;
  reg  [2:0]              tally_ff;
  wire                    window_start;

  reg  [31:0]             ctrl_ff;
  reg  [2:0]              modify_sel_ff;
  reg  [`EVT_COUNT-1:0]   evt_status_ff;
  reg  [`EVT_COUNT-1:0]   evt_mask_ff;
  reg                     irq_ff;

  reg                     aw_held_ff;
  reg  [`AXI_ADDR_W-1:0]  aw_addr_ff;
  reg                     w_held_ff;
  reg  [31:0]             w_data_ff;
  reg  [3:0]              w_strb_ff;
  reg                     bvalid_ff;
  reg  [1:0]              bresp_ff;
  reg                     rvalid_ff;
  reg  [31:0]             rdata_ff;
  reg  [1:0]              rresp_ff;

  wire                    wr_go;
  wire [2:0]              wr_idx;
  wire                    rd_go;
  wire [2:0]              rd_idx;
  reg  [31:0]             rd_word;

  wire                    eof_event;
  wire [`EVT_COUNT-1:0]   evt_raw;
  wire [`EVT_COUNT-1:0]   evt_set;
  wire [`EVT_COUNT-1:0]   evt_clr;
  wire [`EVT_COUNT-1:0]   src_enable;
  wire [`EVT_COUNT-1:0]   evt_pending;
  wire [`EVT_COUNT-1:0]   nxt_evt_status;
  wire [31:0]             nxt_ctrl;
  wire [31:0]             status_word;
  wire [31:0]             ctrl_word;
  wire                    nxt_irq;

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  // Byte-offset to register index, IDX_NONE when unmapped
  function [2:0] reg_index;
    input [`AXI_ADDR_W-1:0] addr;
    begin
      case (addr)
        `OFF_STATUS_INPUTS:   reg_index = `IDX_STATUS_INPUTS;
        `OFF_IRQ_ENABLE_OUTS: reg_index = `IDX_IRQ_ENABLE_OUTS;
        `OFF_MODIFY_SELECT:   reg_index = `IDX_MODIFY_SELECT;
        `OFF_EVENT_STATUS:    reg_index = `IDX_EVENT_STATUS;
        `OFF_EVENT_MASK:      reg_index = `IDX_EVENT_MASK;
        default:              reg_index = `IDX_NONE;
      endcase
    end
  endfunction

  // Merge write data into an old word under byte strobes
  function [31:0] strobe_merge;
    input [31:0] old_word;
    input [31:0] new_word;
    input [3:0]  strb;
    integer      i;
    begin
      strobe_merge = old_word;
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i]) begin
          strobe_merge[i*8 +: 8] = new_word[i*8 +: 8];
        end
      end
    end
  endfunction

  // Event flag held off by the modify selector
  function [`EVT_COUNT-1:0] held_off;
    input [2:0] sel;
    begin
      case (sel)
        `SEL_CTAB:     held_off = 7'h01;
        `SEL_OVERRUN:  held_off = 7'h02;
        `SEL_HARDWARE: held_off = 7'h04;
        `SEL_PULSE:    held_off = 7'h08;
        `SEL_DMA:      held_off = 7'h20;
        `SEL_EOF:      held_off = 7'h40;
        default:       held_off = 7'h00;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_ff   <= 1'b0;
      rst_sync_n_ff <= 1'b0;
    end else begin
      rst_meta_ff   <= 1'b1;
      rst_sync_n_ff <= rst_meta_ff;
    end
  end

  assign rst_sync_n = rst_sync_n_ff;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // two-stage pin sync
  input_sync #(
    .WIDTH (8)
  ) u_pin_sync (
    .clk      (sys_clk),
    .rst_n    (rst_sync_n),
    .async_in ({dip_selector_inputs, general_input_pins, aux_board_present}),
    .sync_out (pins_sync)
  );

  assign aux_sync  = pins_sync[0];
  assign gpin_sync = pins_sync[5:1];
  assign dip_sync  = pins_sync[7:6];

  // ----------------------------------------------------------------
  // Frame tracking and capture command
  // ----------------------------------------------------------------
  assign window_start = frame_window & ~window_ff;

  always @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      window_ff  <= 1'b0;
      cur_cmd_ff <= `CMD_FREEZE;
      tally_ff   <= 3'h0;
    end else begin
      window_ff <= frame_window;
      if (window_start) begin
        cur_cmd_ff <= next_cmd_ff;
        tally_ff   <= tally_ff + 3'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Events and interrupt
  // ----------------------------------------------------------------
  // end-of-frame gating
  assign eof_event = frame_end_pulse &
                     (~ctrl_ff[`FLD_EOF_GATING] |
                      (cur_cmd_ff == `CMD_SNAP) | (cur_cmd_ff == `CMD_GRAB));

  assign evt_raw = {eof_event, dma_descriptor_event, uart_event,
                    external_pulse_event, hardware_event, overrun_event,
                    ctab_event};

  assign evt_set = evt_raw & ~held_off(modify_sel_ff);

  assign evt_clr = (wr_go && wr_idx == `IDX_EVENT_STATUS && w_strb_ff[0]) ?
                   w_data_ff[`EVT_COUNT-1:0] : {`EVT_COUNT{1'b0}};

  // Set wins over a same-cycle clear
  assign nxt_evt_status = (evt_status_ff & ~evt_clr) | evt_set;

  assign src_enable  = {1'b1, ctrl_ff[`FLD_SRC_ENABLE_LSB +: 6]};
  assign evt_pending = evt_status_ff & src_enable & evt_mask_ff;

  assign nxt_irq = ctrl_ff[`FLD_GLOBAL_IRQ_EN] & (|evt_pending);

  always @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      evt_status_ff <= {`EVT_COUNT{1'b0}};
      irq_ff        <= 1'b0;
    end else begin
      evt_status_ff <= nxt_evt_status;
      irq_ff        <= nxt_irq;
    end
  end

  // ----------------------------------------------------------------
  // Write channel
  // ----------------------------------------------------------------
  assign s_axi_awready = ~aw_held_ff;
  assign s_axi_wready  = ~w_held_ff;
  assign wr_go         = aw_held_ff & w_held_ff & ~bvalid_ff;
  assign wr_idx        = reg_index(aw_addr_ff);
  assign nxt_ctrl      = (ctrl_ff & ~`CTRL_WRITE_MASK) |
                         (strobe_merge(ctrl_ff, w_data_ff, w_strb_ff) & `CTRL_WRITE_MASK);

  always @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      aw_held_ff <= 1'b0;
      aw_addr_ff <= {`AXI_ADDR_W{1'b0}};
      w_held_ff  <= 1'b0;
      w_data_ff  <= 32'h00000000;
      w_strb_ff  <= 4'h0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= `AXI_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && !aw_held_ff) begin
        aw_held_ff <= 1'b1;
        aw_addr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_held_ff) begin
        w_held_ff <= 1'b1;
        w_data_ff <= s_axi_wdata;
        w_strb_ff <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_held_ff <= 1'b0;
        w_held_ff  <= 1'b0;
        bvalid_ff  <= 1'b1;
        bresp_ff   <= (wr_idx == `IDX_NONE) ? `AXI_RESP_SLVERR : `AXI_RESP_OKAY;
      end else if (bvalid_ff && s_axi_bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp  = bresp_ff;

  // ----------------------------------------------------------------
  // Writable registers
  // ----------------------------------------------------------------
  always @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      ctrl_ff       <= `RST_CTRL;
      next_cmd_ff   <= `RST_NEXT_CMD;
      modify_sel_ff <= `RST_MODIFY_SELECT;
      evt_mask_ff   <= `RST_EVENT_MASK;
    end else if (wr_go) begin
      case (wr_idx)
        `IDX_STATUS_INPUTS: begin
          if (w_strb_ff[0]) begin
            next_cmd_ff <= w_data_ff[`FLD_NEXT_CMD_LSB +: 2];
          end
        end
        `IDX_IRQ_ENABLE_OUTS: begin
          ctrl_ff <= nxt_ctrl;
        end
        `IDX_MODIFY_SELECT: begin
          if (w_strb_ff[0]) begin
            modify_sel_ff <= w_data_ff[2:0];
          end
        end
        `IDX_EVENT_MASK: begin
          if (w_strb_ff[0]) begin
            evt_mask_ff <= w_data_ff[`EVT_COUNT-1:0];
          end
        end
        default: begin
          ctrl_ff <= ctrl_ff;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Read words
  // ----------------------------------------------------------------
  // status word
  assign status_word = {dip_sync, gpin_sync, aux_sync, 16'h0000,
                        tally_ff, window_ff, cur_cmd_ff, next_cmd_ff};

  assign ctrl_word = {ctrl_ff[31:8], irq_ff, ctrl_ff[6:0]};

  assign rd_idx = reg_index(s_axi_araddr);
  assign rd_go  = s_axi_arvalid & ~rvalid_ff;

  always @* begin
    case (rd_idx)
      `IDX_STATUS_INPUTS:   rd_word = status_word;
      `IDX_IRQ_ENABLE_OUTS: rd_word = ctrl_word;
      `IDX_MODIFY_SELECT:   rd_word = {29'h00000000, modify_sel_ff};
      `IDX_EVENT_STATUS:    rd_word = {25'h0000000, evt_status_ff};
      `IDX_EVENT_MASK:      rd_word = {25'h0000000, evt_mask_ff};
      default:              rd_word = 32'h00000000;
    endcase
  end

  // ----------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------
  assign s_axi_arready = ~rvalid_ff;

  always @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= 32'h00000000;
      rresp_ff  <= `AXI_RESP_OKAY;
    end else begin
      if (rd_go) begin
        rvalid_ff <= 1'b1;
        rdata_ff  <= rd_word;
        rresp_ff  <= (rd_idx == `IDX_NONE) ? `AXI_RESP_SLVERR : `AXI_RESP_OKAY;
      end else if (rvalid_ff && s_axi_rready) begin
        rvalid_ff <= 1'b0;
      end
    end
  end

  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata  = rdata_ff;
  assign s_axi_rresp  = rresp_ff;

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // output pins from register
  assign general_output_pins     = ctrl_ff[`FLD_GPOUT_LSB +: 7];
  assign current_capture_command = cur_cmd_ff;
  assign irq                     = irq_ff;

endmodule // acq_status_irq_enable_regs

// *** tb/acq_regs_sva.sv ***
// Port-level checker for the acquisition register bank.
// Assumes one clock domain; bound to the bank at the foot of this file.
`timescale 1ns/1ps

module acq_regs_sva (
  // Clock and reset
  input logic        sys_clk, rst_n,
  // Bus
  input logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready,
  input logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready,
  input logic        s_axi_rvalid, s_axi_rready,
  input logic [1:0]  s_axi_bresp, s_axi_rresp,
  input logic [7:0]  s_axi_araddr,
  input logic [31:0] s_axi_rdata,
  // Frame and events
  input logic        frame_window, frame_end_pulse, ctab_event, overrun_event,
  input logic        hardware_event, external_pulse_event, uart_event, dma_descriptor_event,
  // Outputs
  input logic [6:0]  general_output_pins,
  input logic [1:0]  current_capture_command,
  input logic        irq
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  wire any_ev = frame_end_pulse | ctab_event | overrun_event | hardware_event
              | external_pulse_event | uart_event | dma_descriptor_event;

  a_cmd_at_start: assert property (!$stable(current_capture_command) |->
    $past(frame_window) && !$past(frame_window, 2)) else $error("command changed off frame start");
  a_gpout_on_write: assert property (!$stable(general_output_pins) |->
    $rose(s_axi_bvalid)) else $error("output pins changed without a write");
  a_irq_rise_cause: assert property ($rose(irq) |->
    $past(any_ev, 2) || $past(s_axi_bvalid)) else $error("interrupt rose without a cause");
  a_irq_fall_cause: assert property ($fell(irq) |-> $past(s_axi_bvalid))
    else $error("interrupt fell without a write");
  a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  a_read_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_write_latency: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid) else $error("write answer late");
  a_unmapped_err: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h13
    |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0) else $error("unmapped read not refused");

  c_irq: cover property ($rose(irq));
  c_cmd: cover property (!$stable(current_capture_command));
  c_err: cover property ($rose(s_axi_rvalid) && s_axi_rresp == 2'h2);
endmodule // acq_regs_sva

bind acq_status_irq_enable_regs acq_regs_sva u_sva (.sys_clk, .rst_n, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .s_axi_rready, .s_axi_bresp, .s_axi_rresp, .s_axi_araddr, .s_axi_rdata,
  .frame_window, .frame_end_pulse, .ctab_event, .overrun_event, .hardware_event,
  .external_pulse_event, .uart_event, .dma_descriptor_event, .general_output_pins,
  .current_capture_command, .irq);

// *** tb/testbench.sv ***
// Self-checking bench for the acquisition register bank over AXI4-Lite.
// Assumes the bank and its checker are compiled first.
`timescale 1ns/1ps
`include "acq_regs_defines.vh"

module testbench;
  // ----
  // Signals
  // ----
  logic        sys_clk = 0, rst_n = 0, fw = 0, aux = 0;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [7:0]  awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, d;
  logic [6:0]  ev = 0, gpout;
  logic [4:0]  gpin = 0;
  logic [1:0]  dip = 0, bresp, rresp, cur;
  logic [2:0]  tally = 0;
  logic        awready, wready, bvalid, arready, rvalid, irq;
  int          miscompares = 0, num_checks = 0, i, k, m, g, b;

  always #4 sys_clk = ~sys_clk;

  acq_status_irq_enable_regs dut (.sys_clk(sys_clk), .rst_n(rst_n), .s_axi_awaddr(awaddr),
    .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .frame_window(fw), .frame_end_pulse(ev[6]),
    .ctab_event(ev[0]), .overrun_event(ev[1]), .hardware_event(ev[2]), .external_pulse_event(ev[3]),
    .uart_event(ev[4]), .dma_descriptor_event(ev[5]), .aux_board_present(aux),
    .general_input_pins(gpin), .dip_selector_inputs(dip), .general_output_pins(gpout),
    .current_capture_command(cur), .irq(irq));

  // ----
  // Tasks
  // ----
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: saw %h, want %h", $time, seen, exp);
    end
  endtask

  task automatic results;
    $display("checks %0d, miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic hang;
    miscompares++;
    $display("unexpected at %0t: bus handshake timed out", $time);
    results;
  endtask

  // Expected status word from the pin levels driven
  function automatic logic [31:0] status_exp(input logic [2:0] t, input logic w, input logic [1:0] c);
    return {dip, gpin, aux, 16'h0, t, w, c, c};
  endfunction

  // Ready held high; response taken at the handshake edge
  task automatic wr(input logic [7:0] a, input logic [31:0] dt, input logic [1:0] er);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= dt;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    do begin
      @(posedge sys_clk);
      if (awvalid && awready) awvalid <= 0;
      if (wvalid && wready) wvalid <= 0;
      if (++n > 50) hang;
    end while (!bvalid);
    chk(bresp, er);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do begin
      @(posedge sys_clk);
      if (arvalid && arready) arvalid <= 0;
      if (++n > 50) hang;
    end while (!rvalid);
    chk(rdata, exp);
    chk(rresp, er);
  endtask

  task automatic pulse(input int bi);
    ev[bi] <= 1;
    @(posedge sys_clk);
    ev[bi] <= 0;
    repeat (3) @(posedge sys_clk);
  endtask

  task automatic frame(input logic [1:0] c);
    fw <= 1;
    tally++;
    repeat (2) @(posedge sys_clk);
    rchk(8'h00, status_exp(tally, 1'b1, c), 2'h0);
    fw <= 0;
    pulse(6);
    chk(cur, c);
  endtask

  // ----
  // Sequence
  // ----
  initial begin
    void'($urandom(60428));
    repeat (20) @(posedge sys_clk);
    rst_n <= 1;
    repeat (3) @(posedge sys_clk);
    for (i = 0; i < 5; i++) begin
      rchk(8'h04 * i, 32'h0, 2'h0);
      {dip, gpin, aux} <= 8'($urandom);
      repeat (3) @(posedge sys_clk);
      rchk(8'h00, status_exp(3'h0, 1'b0, 2'h0), 2'h0);
    end
    $display("test reset and pins done");
    for (i = 0; i < 6; i++) begin
      d = $urandom;
      wr(8'h04, d, 2'h0);
      rchk(8'h04, d & `CTRL_WRITE_MASK, 2'h0);
      chk(gpout, d[16:10]);
    end
    wr(8'h04, 32'h0, 2'h0);
    $display("test control word done");
    for (i = 0; i < 9; i++) begin
      wr(8'h00, i % 4, 2'h0);
      chk(cur, i == 0 ? 0 : (i - 1) % 4);
      frame(i % 4);
    end
    wr(8'h0C, 32'h7F, 2'h0);
    $display("test commands and tally done");
    for (i = 0; i < 6; i++)
      for (m = 0; m < 4; m++) begin
        d = m == 2 ? 32'h3F : m == 1 ? 32'h13F ^ (1 << i) : 32'h13F;
        wr(8'h04, d, 2'h0);
        wr(8'h10, m == 3 ? 32'h7F ^ (1 << i) : 32'h7F, 2'h0);
        pulse(i);
        chk(irq, m == 0);
        rchk(8'h0C, 1 << i, 2'h0);
        rchk(8'h04, d | (32'(m == 0) << 7), 2'h0);
        wr(8'h0C, 1 << i, 2'h0);
        repeat (2) @(posedge sys_clk);
        chk(irq, 0);
      end
    wr(8'h10, 32'h7F, 2'h0);
    $display("test interrupts done");
    for (g = 0; g < 2; g++)
      for (k = 0; k < 4; k++) begin
        wr(8'h04, 32'h100 | (g << 6), 2'h0);
        wr(8'h00, k, 2'h0);
        frame(k);
        b = (g == 0 || k > 1);
        chk(irq, b);
        rchk(8'h0C, b << 6, 2'h0);
        wr(8'h0C, 32'h40, 2'h0);
      end
    $display("test end of frame gating done");
    wr(8'h04, 32'h0, 2'h0);
    for (k = 1; k < 7; k++) begin
      b = k < 5 ? k - 1 : k;
      wr(8'h08, k, 2'h0);
      pulse(b);
      rchk(8'h0C, 32'h0, 2'h0);
      wr(8'h08, 32'h0, 2'h0);
      pulse(b);
      rchk(8'h0C, 1 << b, 2'h0);
      wr(8'h0C, 32'h7F, 2'h0);
    end
    $display("test modify selector done");
    rchk(8'h40, 32'h0, 2'h2);
    rchk(8'h05, 32'h0, 2'h2);
    wr(8'h40, 32'hFFFFFFFF, 2'h2);
    rchk(8'h04, 32'h0, 2'h0);
    $display("test unmapped done");
    results;
  end
endmodule // testbench
